// ==== design/fcpwm_consts.svh ====
`ifndef FCPWM_CONSTS_SVH
`define FCPWM_CONSTS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define FCPWM_IDX_MAIN_CTRL 8'hdc
`define FCPWM_IDX_BRAKE_CTRL 8'hdf
`define FCPWM_IDX_PERIOD 8'he0
`define FCPWM_IDX_CMP0 8'he1
`define FCPWM_IDX_CMP1 8'he2
`define FCPWM_IDX_CMP2 8'he3
`define FCPWM_IDX_CMP3 8'he4
`define FCPWM_IDX_STATUS 8'he5

// ----------------------------------------
// Main control field positions
// ----------------------------------------
`define FCPWM_RUN_BIT 7
`define FCPWM_LOAD_BIT 6
`define FCPWM_CF_BIT 5
`define FCPWM_CLR_BIT 4
`define FCPWM_INV_LSB 0

// ----------------------------------------
// Brake control field positions
// ----------------------------------------
`define FCPWM_BK_STOPPED_BIT 7
`define FCPWM_BK_POL_BIT 6
`define FCPWM_BK_PIN_BIT 5
`define FCPWM_BK_EN_BIT 4
`define FCPWM_BK_LEVEL_LSB 0

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define FCPWM_ST_BRAKE_FLAG_BIT 0
`define FCPWM_ST_BRAKE_ACTIVE_BIT 1
`define FCPWM_ST_CNT_LSB 16

// ----------------------------------------
// Reset values and special codes
// ----------------------------------------
`define FCPWM_MAIN_RESET 8'h00
`define FCPWM_BRAKE_RESET 8'h00
`define FCPWM_VAL_RESET 10'h000
`define FCPWM_CMP_ALL_ZERO 10'h000
`define FCPWM_CMP_ALL_ONE 10'h3ff
`define FCPWM_RAW_RESET 1'b1

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define FCPWM_RESP_OKAY 2'b00
`define FCPWM_RESP_SLVERR 2'b10

`endif

// ==== design/fcpwm_pkg.sv ====
package fcpwm_pkg;

	typedef logic [9:0] fcpwm_val_t;
	typedef logic [7:0] fcpwm_idx_t;
	typedef logic [7:0] fcpwm_byte_t;

	typedef enum logic [1:0]
	{
		FCPWM_BRK_ALWAYS,
		FCPWM_BRK_STOPPED,
		FCPWM_BRK_PIN,
		FCPWM_BRK_NONE
	} fcpwm_brake_mode_t;

endpackage : fcpwm_pkg

// ==== design/fcpwm_reg_if.sv ====
`timescale 1ns/1ns
interface fcpwm_reg_if;
	import fcpwm_pkg::*;

	logic wr_stb;
	fcpwm_idx_t wr_idx;
	logic [31:0] wr_data;
	logic wr_ok;
	fcpwm_idx_t rd_idx;
	logic [31:0] rd_data;
	logic rd_ok;

	modport bus
	(
		output wr_stb, wr_idx, wr_data, rd_idx,
		input wr_ok, rd_data, rd_ok
	);

	modport core
	(
		input wr_stb, wr_idx, wr_data, rd_idx,
		output wr_ok, rd_data, rd_ok
	);

endinterface : fcpwm_reg_if

// ==== design/fcpwm_axil.sv ====
`timescale 1ns/1ns
`include "fcpwm_consts.svh"
module fcpwm_axil
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	fcpwm_reg_if.bus regs
);
	import fcpwm_pkg::*;

	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic aw_full_q;
	logic w_full_q;
	logic wr_go;
	logic wr_aligned;

	// ----------------------------------------
	// Write path
	// ----------------------------------------
	assign wr_go = aw_full_q && w_full_q && !s_axi_bvalid;
	assign wr_aligned = (awaddr_q[1:0] == 2'b00) && (awaddr_q[11:10] == 2'b00);
	assign regs.wr_idx = awaddr_q[9:2];
	assign regs.wr_data = wdata_q;
	assign regs.wr_stb = wr_go && wr_aligned && regs.wr_ok && wstrb_q[0];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full_q <= 1'b0;
			s_axi_awready <= 1'b0;
			awaddr_q <= 12'h000;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_full_q <= 1'b1;
			s_axi_awready <= 1'b0;
			awaddr_q <= s_axi_awaddr;
		end
		else if (s_axi_bvalid && s_axi_bready)
		begin
			aw_full_q <= 1'b0;
			s_axi_awready <= 1'b1;
		end
		else if (!aw_full_q)
			s_axi_awready <= 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_full_q <= 1'b0;
			s_axi_wready <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_full_q <= 1'b1;
			s_axi_wready <= 1'b0;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end
		else if (s_axi_bvalid && s_axi_bready)
		begin
			w_full_q <= 1'b0;
			s_axi_wready <= 1'b1;
		end
		else if (!w_full_q)
			s_axi_wready <= 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `FCPWM_RESP_OKAY;
		end
		else if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wr_aligned && regs.wr_ok) ? `FCPWM_RESP_OKAY : `FCPWM_RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	assign regs.rd_idx = s_axi_araddr[9:2];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `FCPWM_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			if (regs.rd_ok && s_axi_araddr[1:0] == 2'b00 && s_axi_araddr[11:10] == 2'b00)
			begin
				s_axi_rdata <= regs.rd_data;
				s_axi_rresp <= `FCPWM_RESP_OKAY;
			end
			else
			begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= `FCPWM_RESP_SLVERR;
			end
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
		else if (!s_axi_rvalid)
			s_axi_arready <= 1'b1;
	end

endmodule : fcpwm_axil

// ==== design/fcpwm_chan.sv ====
`timescale 1ns/1ns
`include "fcpwm_consts.svh"
module fcpwm_chan
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire fcpwm_pkg::fcpwm_val_t cnt,
	input wire fcpwm_pkg::fcpwm_val_t cmp,
	input wire fcpwm_pkg::fcpwm_val_t period,
	input wire logic invert,
	input wire logic brake,
	input wire logic brake_level,
	output logic pwm_out
);
	import fcpwm_pkg::*;

	logic raw_q;
	logic raw_d;

	// ----------------------------------------
	// Compare with special cases
	// ----------------------------------------
	always_comb
	begin
		if (cmp == `FCPWM_CMP_ALL_ZERO)
			raw_d = 1'b1;
		else if (cmp == `FCPWM_CMP_ALL_ONE)
			raw_d = 1'b0;
		else if (cmp > period)
			raw_d = 1'b0;
		else
			raw_d = (cnt >= cmp);
	end

	// Level freezes while stopped
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			raw_q <= `FCPWM_RAW_RESET;
		else if (run)
			raw_q <= raw_d;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pwm_out <= `FCPWM_RAW_RESET;
		else if (brake)
			pwm_out <= brake_level;
		else
			pwm_out <= raw_q ^ invert;
	end

endmodule : fcpwm_chan

// ==== design/fcpwm_top.sv ====
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "fcpwm_consts.svh"
// Contract
// - Compare above reload period holds that output low.
// - Compare of zero holds that output high.
// - Compare of all ones holds that output low.
// - Per-channel invert bits in main control bits 3..0 flip the output.
// - Main control bit 7 stops or runs the ten-bit counter.
// - Load bit 6 moves buffered period and compares to working at underflow.
// - Without load bit, buffered values never reach working registers.
// - Underflow of the down counter sets flag bit 5.
// - The underflow flag raises no interrupt.
// - Load bit and underflow flag clear one cycle after a transfer.
// - Writing 1 to bit 4 forces the counter to zero.
// - Load without run never transfers; later run-only write keeps old values.
// - Rewriting run without load before underflow cancels the pending transfer.
// - Clearing run freezes every output at its previous level unless the brake is asserted.
// - Brake control bit 4 enables the brake, else never asserted.
// - Brake control bit 6 picks the active level of the brake pin.
// - Asserted brake drives each output to its brake-level bit.
// - Mode bits 7 and 5: always, when stopped, from pin; both none.
// - Pin brake clears run, sets the brake flag and stops the waveform.
// - Output high until counter drops below compare, low until underflow.
module fcpwm_top
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic brake_input_pin,
	output logic [3:0] pwm_out
);
	import fcpwm_pkg::*;

	fcpwm_reg_if regs ();

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic generator_run_q;
	logic load_request_q;
	logic counter_underflow_flag_q;
	logic [3:0] channel_invert_q;
	fcpwm_byte_t pwm_brake_control_q;
	logic brake_pin_flag_q;
	logic xfer_done_q;
	fcpwm_val_t period_buf_q;
	fcpwm_val_t period_work_q;
	fcpwm_val_t cnt_q;
	fcpwm_val_t cmp_buf_q [4];
	fcpwm_val_t cmp_work_q [4];

	// ----------------------------------------
	// Decoded events
	// ----------------------------------------
	logic wr_main;
	logic wr_brake;
	logic wr_period;
	logic wr_status;
	logic [3:0] wr_cmp;
	logic counter_clear;
	logic underflow;
	logic transfer;
	logic brake_pin_level;
	logic brake_pin_hit;
	logic brake_active;
	fcpwm_brake_mode_t brake_mode;

	assign wr_main = regs.wr_stb && regs.wr_idx == `FCPWM_IDX_MAIN_CTRL;
	assign wr_brake = regs.wr_stb && regs.wr_idx == `FCPWM_IDX_BRAKE_CTRL;
	assign wr_period = regs.wr_stb && regs.wr_idx == `FCPWM_IDX_PERIOD;
	assign wr_status = regs.wr_stb && regs.wr_idx == `FCPWM_IDX_STATUS;
	assign wr_cmp[0] = regs.wr_stb && regs.wr_idx == `FCPWM_IDX_CMP0;
	assign wr_cmp[1] = regs.wr_stb && regs.wr_idx == `FCPWM_IDX_CMP1;
	assign wr_cmp[2] = regs.wr_stb && regs.wr_idx == `FCPWM_IDX_CMP2;
	assign wr_cmp[3] = regs.wr_stb && regs.wr_idx == `FCPWM_IDX_CMP3;

	assign counter_clear = wr_main && regs.wr_data[`FCPWM_CLR_BIT];

	// Underflow only while counting
	assign underflow = generator_run_q && !counter_clear && cnt_q == `FCPWM_VAL_RESET;
	assign transfer = underflow && load_request_q;

	// ----------------------------------------
	// Brake decode
	// ----------------------------------------
	always_comb
	begin
		unique case ({pwm_brake_control_q[`FCPWM_BK_PIN_BIT], pwm_brake_control_q[`FCPWM_BK_STOPPED_BIT]})
			2'b00: brake_mode = FCPWM_BRK_ALWAYS;
			2'b01: brake_mode = FCPWM_BRK_STOPPED;
			2'b10: brake_mode = FCPWM_BRK_PIN;
			2'b11: brake_mode = FCPWM_BRK_NONE;
		endcase
	end

	// Pin asserts at the selected polarity
	assign brake_pin_level = pwm_brake_control_q[`FCPWM_BK_POL_BIT] ? brake_input_pin : !brake_input_pin;

	assign brake_pin_hit = pwm_brake_control_q[`FCPWM_BK_EN_BIT] && brake_mode == FCPWM_BRK_PIN && brake_pin_level;

	always_comb
	begin
		brake_active = 1'b0;
		if (pwm_brake_control_q[`FCPWM_BK_EN_BIT])
		begin
			unique case (brake_mode)
				FCPWM_BRK_ALWAYS: brake_active = 1'b1;
				FCPWM_BRK_STOPPED: brake_active = !generator_run_q;
				FCPWM_BRK_PIN: brake_active = brake_pin_level;
				FCPWM_BRK_NONE: brake_active = 1'b0;
			endcase
		end
	end

	// ----------------------------------------
	// Main control register
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			generator_run_q <= 1'(`FCPWM_MAIN_RESET >> `FCPWM_RUN_BIT);
		else if (brake_pin_hit)
			generator_run_q <= 1'b0;
		else if (wr_main)
			generator_run_q <= regs.wr_data[`FCPWM_RUN_BIT];
	end

	// Rewrite without load drops a pending transfer
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			load_request_q <= 1'b0;
		else if (xfer_done_q)
			load_request_q <= 1'b0;
		else if (wr_main)
			load_request_q <= regs.wr_data[`FCPWM_LOAD_BIT];
	end

	// Hardware set wins over a same-cycle software write
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			counter_underflow_flag_q <= 1'b0;
		else if (underflow)
			counter_underflow_flag_q <= 1'b1;
		else if (xfer_done_q)
			counter_underflow_flag_q <= 1'b0;
		else if (wr_main)
			counter_underflow_flag_q <= regs.wr_data[`FCPWM_CF_BIT];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			xfer_done_q <= 1'b0;
		else
			xfer_done_q <= transfer;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			channel_invert_q <= 4'h0;
		else if (wr_main)
			channel_invert_q <= regs.wr_data[`FCPWM_INV_LSB +: 4];
	end

	// ----------------------------------------
	// Brake control and flag
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pwm_brake_control_q <= `FCPWM_BRAKE_RESET;
		else if (wr_brake)
			pwm_brake_control_q <= regs.wr_data[7:0];
	end

	// Software clears by writing zero; pin event wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			brake_pin_flag_q <= 1'b0;
		else if (brake_pin_hit)
			brake_pin_flag_q <= 1'b1;
		else if (wr_status && !regs.wr_data[`FCPWM_ST_BRAKE_FLAG_BIT])
			brake_pin_flag_q <= 1'b0;
	end

	// ----------------------------------------
	// Buffered period and compares
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			period_buf_q <= `FCPWM_VAL_RESET;
		else if (wr_period)
			period_buf_q <= regs.wr_data[9:0];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			period_work_q <= `FCPWM_VAL_RESET;
		else if (transfer)
			period_work_q <= period_buf_q;
	end

	// ----------------------------------------
	// Down counter
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_q <= `FCPWM_VAL_RESET;
		else if (counter_clear)
			cnt_q <= `FCPWM_VAL_RESET;
		else if (transfer)
			cnt_q <= period_buf_q;
		else if (underflow)
			cnt_q <= period_work_q;
		else if (generator_run_q)
			cnt_q <= cnt_q - 10'h001;
	end

	// ----------------------------------------
	// Channels
	// ----------------------------------------
	for (genvar ch = 0; ch < 4; ch++)
	begin : g_chan
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				cmp_buf_q[ch] <= `FCPWM_VAL_RESET;
			else if (wr_cmp[ch])
				cmp_buf_q[ch] <= regs.wr_data[9:0];
		end

		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				cmp_work_q[ch] <= `FCPWM_VAL_RESET;
			else if (transfer)
				cmp_work_q[ch] <= cmp_buf_q[ch];
		end

		fcpwm_chan u_chan
		(
			.aclk(aclk),
			.aresetn(aresetn),
			.run(generator_run_q),
			.cnt(cnt_q),
			.cmp(cmp_work_q[ch]),
			.period(period_work_q),
			.invert(channel_invert_q[ch]),
			.brake(brake_active),
			.brake_level(pwm_brake_control_q[`FCPWM_BK_LEVEL_LSB + ch]),
			.pwm_out(pwm_out[ch])
		);
	end

	// ----------------------------------------
	// Register read and decode answers
	// ----------------------------------------
	always_comb
	begin
		regs.rd_data = 32'h0000_0000;
		regs.rd_ok = 1'b1;
		unique case (regs.rd_idx)
			`FCPWM_IDX_MAIN_CTRL:
			begin
				regs.rd_data[`FCPWM_RUN_BIT] = generator_run_q;
				regs.rd_data[`FCPWM_LOAD_BIT] = load_request_q;
				regs.rd_data[`FCPWM_CF_BIT] = counter_underflow_flag_q;
				regs.rd_data[`FCPWM_INV_LSB +: 4] = channel_invert_q;
			end
			`FCPWM_IDX_BRAKE_CTRL: regs.rd_data[7:0] = pwm_brake_control_q;
			`FCPWM_IDX_PERIOD: regs.rd_data[9:0] = period_buf_q;
			`FCPWM_IDX_CMP0: regs.rd_data[9:0] = cmp_buf_q[0];
			`FCPWM_IDX_CMP1: regs.rd_data[9:0] = cmp_buf_q[1];
			`FCPWM_IDX_CMP2: regs.rd_data[9:0] = cmp_buf_q[2];
			`FCPWM_IDX_CMP3: regs.rd_data[9:0] = cmp_buf_q[3];
			`FCPWM_IDX_STATUS:
			begin
				regs.rd_data[`FCPWM_ST_BRAKE_FLAG_BIT] = brake_pin_flag_q;
				regs.rd_data[`FCPWM_ST_BRAKE_ACTIVE_BIT] = brake_active;
				regs.rd_data[`FCPWM_ST_CNT_LSB +: 10] = cnt_q;
			end
			default: regs.rd_ok = 1'b0;
		endcase
	end

	always_comb
	begin
		unique case (regs.wr_idx)
			`FCPWM_IDX_MAIN_CTRL, `FCPWM_IDX_BRAKE_CTRL, `FCPWM_IDX_PERIOD, `FCPWM_IDX_STATUS,
			`FCPWM_IDX_CMP0, `FCPWM_IDX_CMP1, `FCPWM_IDX_CMP2, `FCPWM_IDX_CMP3: regs.wr_ok = 1'b1;
			default: regs.wr_ok = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	fcpwm_axil u_axil
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.regs(regs)
	);

endmodule : fcpwm_top

// ==== sim/fcpwm_top_asserts.sv ====
`timescale 1ns/1ns
`include "fcpwm_consts.svh"
module fcpwm_top_asserts
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic brake_input_pin,
	input wire logic [3:0] pwm_out
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic [11:0] wa_q;
	logic [7:0] wd_q;
	logic ws_q;
	logic bseen_q;
	logic [7:0] main_q;
	logic [7:0] brk_q;
	logic bk_on;
	// ----------------------------------------
	// Shadow of written controls, one cycle late
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wa_q <= 12'h000;
			wd_q <= 8'h00;
			ws_q <= 1'b0;
			bseen_q <= 1'b0;
			main_q <= 8'h00;
			brk_q <= 8'h00;
		end
		else
		begin
			bseen_q <= s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready)
				wa_q <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready)
				wd_q <= s_axi_wdata[7:0];
			if (s_axi_wvalid && s_axi_wready)
				ws_q <= s_axi_wstrb[0];
			if (s_axi_bvalid && !bseen_q && ws_q && wa_q == {2'b00, `FCPWM_IDX_MAIN_CTRL, 2'b00})
				main_q <= wd_q;
			if (s_axi_bvalid && !bseen_q && ws_q && wa_q == {2'b00, `FCPWM_IDX_BRAKE_CTRL, 2'b00})
				brk_q <= wd_q;
		end
	end
	assign bk_on = brk_q[4] && !brk_q[7] && (!brk_q[5] || brake_input_pin == brk_q[6]);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_aw_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("write address ready stayed high after taking");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write response late");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	a_ready_return: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
		else $error("write readys not back after response");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data late");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data changed before taken");
	a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
		else $error("refused read returned data");
	a_brake_levels: assert property (
		bk_on && $past(bk_on) && $past(brk_q) == brk_q && !s_axi_bvalid |-> pwm_out == brk_q[3:0])
		else $error("outputs not at brake levels");
	a_stop_freeze: assert property (
		!main_q[7] && $past(main_q) == main_q && $past(main_q, 2) == main_q && $past(brk_q) == brk_q
		&& $past(brk_q, 2) == brk_q && $stable(brake_input_pin) && $past(brake_input_pin, 2) == brake_input_pin
		&& !s_axi_bvalid && !$past(s_axi_bvalid) |-> $stable(pwm_out))
		else $error("outputs moved while stopped");
endmodule : fcpwm_top_asserts

bind fcpwm_top fcpwm_top_asserts u_chk (.*);

// ==== sim/fcpwm_load.sv ====
`timescale 1ns/1ns
module fcpwm_load
(
	input wire logic aclk,
	input wire logic [3:0] pwm_out,
	input wire logic clear,
	input wire logic press,
	input wire logic active_high,
	output logic brake_input_pin,
	output logic [3:0][7:0] high_cnt
);
	// ----------------------------------------
	// Brake switch, released level when idle
	// ----------------------------------------
	assign brake_input_pin = press ? active_high : !active_high;
	// ----------------------------------------
	// High time seen by each load
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		for (int i = 0; i < 4; i++)
		begin
			if (clear)
				high_cnt[i] <= 8'h00;
			else
				high_cnt[i] <= high_cnt[i] + {7'h00, pwm_out[i]};
		end
	end
endmodule : fcpwm_load

// ==== sim/fcpwm_top_tb.sv ====
`timescale 1ns/1ns
`include "fcpwm_consts.svh"
module fcpwm_top_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic [11:0] s_axi_araddr = 12'h000;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, brake_input_pin;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [3:0] pwm_out;
	logic [3:0][7:0] high_cnt;
	logic press = 1'b0;
	logic act_high = 1'b0;
	logic clear = 1'b0;
	int bad_count = 0;
	int samples_checked = 0;
	int lag = 0;
	always #10 aclk = ~aclk;
	fcpwm_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.brake_input_pin(brake_input_pin), .pwm_out(pwm_out));
	fcpwm_load u_load (.aclk(aclk), .pwm_out(pwm_out), .clear(clear), .press(press), .active_high(act_high),
		.brake_input_pin(brake_input_pin), .high_cnt(high_cnt));
	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	task automatic wrap_up();
		if (bad_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [11:0] ad(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction : ad
	task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (s_axi_bvalid && s_axi_bready)
				break;
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (n == lag)
				s_axi_bready <= 1'b1;
			n++;
		end
		s_axi_bready <= 1'b0;
		chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, er});
	endtask : axw
	task automatic axr(input logic [11:0] a, input logic [1:0] er, input logic [31:0] m, input logic [31:0] ed);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (s_axi_rvalid && s_axi_rready)
				break;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (n == lag)
				s_axi_rready <= 1'b1;
			n++;
		end
		s_axi_rready <= 1'b0;
		chk({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, er});
		chk(s_axi_rdata & m, ed);
	endtask : axr
	task automatic duty(input logic [31:0] e);
		clear <= 1'b1;
		@(posedge aclk);
		clear <= 1'b0;
		repeat (40) @(posedge aclk);
		@(negedge aclk);
		chk(high_cnt, e);
		@(posedge aclk);
	endtask : duty
	task automatic outs(input logic [3:0] e);
		repeat (3) @(posedge aclk);
		@(negedge aclk);
		chk({28'h0, pwm_out}, {28'h0, e});
		@(posedge aclk);
	endtask : outs
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		lag = 3;
		axr(ad(`FCPWM_IDX_MAIN_CTRL), 2'b00, 32'hffffffff, 32'h0);
		axr(ad(`FCPWM_IDX_BRAKE_CTRL), 2'b00, 32'hffffffff, 32'h0);
		axr(ad(8'h10), 2'b10, 32'hffffffff, 32'h0);
		axw(ad(8'h10), 32'h5, 2'b10);
		lag = 0;
		outs(4'hf);
	endtask : t_reset
	task automatic t_run();
		axw(ad(`FCPWM_IDX_PERIOD), 32'd9, 2'b00);
		axw(ad(`FCPWM_IDX_CMP0), 32'd3, 2'b00);
		axw(ad(`FCPWM_IDX_CMP1), 32'h0, 2'b00);
		axw(ad(`FCPWM_IDX_CMP2), 32'h3ff, 2'b00);
		axw(ad(`FCPWM_IDX_CMP3), 32'd12, 2'b00);
		axw(ad(`FCPWM_IDX_MAIN_CTRL), 32'hc1, 2'b00);
		repeat (3) @(posedge aclk);
		axr(ad(`FCPWM_IDX_MAIN_CTRL), 2'b00, 32'hff, 32'h81);
		repeat (20) @(posedge aclk);
		axr(ad(`FCPWM_IDX_MAIN_CTRL), 2'b00, 32'hff, 32'ha1);
		duty({8'd0, 8'd0, 8'd40, 8'd12});
	endtask : t_run
	task automatic t_hold();
		axw(ad(`FCPWM_IDX_PERIOD), 32'd4, 2'b00);
		axw(ad(`FCPWM_IDX_CMP0), 32'd1, 2'b00);
		duty({8'd0, 8'd0, 8'd40, 8'd12});
		axw(ad(`FCPWM_IDX_MAIN_CTRL), 32'h01, 2'b00);
		repeat (20) @(posedge aclk);
		axw(ad(`FCPWM_IDX_MAIN_CTRL), 32'h41, 2'b00);
		repeat (30) @(posedge aclk);
		// Clear fixes the phase so the load is cancelled well before underflow
		axw(ad(`FCPWM_IDX_MAIN_CTRL), 32'h91, 2'b00);
		axw(ad(`FCPWM_IDX_MAIN_CTRL), 32'hc1, 2'b00);
		axw(ad(`FCPWM_IDX_MAIN_CTRL), 32'h81, 2'b00);
		duty({8'd0, 8'd0, 8'd40, 8'd12});
		axw(ad(`FCPWM_IDX_MAIN_CTRL), 32'hc1, 2'b00);
		repeat (12) @(posedge aclk);
		duty({8'd0, 8'd0, 8'd40, 8'd8});
	endtask : t_hold
	task automatic t_clear();
		axw(ad(`FCPWM_IDX_MAIN_CTRL), 32'h11, 2'b00);
		axr(ad(`FCPWM_IDX_STATUS), 2'b00, 32'h03ff0000, 32'h0);
		axr(ad(`FCPWM_IDX_MAIN_CTRL), 2'b00, 32'hff, 32'h01);
	endtask : t_clear
	task automatic t_brake();
		axw(ad(`FCPWM_IDX_BRAKE_CTRL), 32'h15, 2'b00);
		outs(4'h5);
		axw(ad(`FCPWM_IDX_BRAKE_CTRL), 32'h9c, 2'b00);
		outs(4'hc);
		axw(ad(`FCPWM_IDX_MAIN_CTRL), 32'h80, 2'b00);
		axw(ad(`FCPWM_IDX_BRAKE_CTRL), 32'h3a, 2'b00);
		axr(ad(`FCPWM_IDX_STATUS), 2'b00, 32'h3, 32'h0);
		press <= 1'b1;
		outs(4'ha);
		axr(ad(`FCPWM_IDX_STATUS), 2'b00, 32'h3, 32'h3);
		axr(ad(`FCPWM_IDX_MAIN_CTRL), 2'b00, 32'h80, 32'h0);
		press <= 1'b0;
		act_high <= 1'b1;
		axw(ad(`FCPWM_IDX_BRAKE_CTRL), 32'h7a, 2'b00);
		press <= 1'b1;
		outs(4'ha);
		axw(ad(`FCPWM_IDX_BRAKE_CTRL), 32'h0a, 2'b00);
		axr(ad(`FCPWM_IDX_STATUS), 2'b00, 32'h2, 32'h0);
	endtask : t_brake
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_reset();
		t_run();
		t_hold();
		t_clear();
		t_brake();
		wrap_up();
	end
	initial
	begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		wrap_up();
	end
endmodule : fcpwm_top_tb
